// File: hdl/agpsb_pkg.sv
// Shared constants and types for the sideband master link
package agpsb_pkg;
  localparam int unsigned STATUS_W = 3;
  localparam int unsigned AD_W     = 32;
  localparam int unsigned CBE_W    = 4;
  localparam int unsigned BLK_CLKS = 4;
  localparam logic [2:0] ST_LP_READ  = 3'h0;
  localparam logic [2:0] ST_HP_READ  = 3'h1;
  localparam logic [2:0] ST_LP_WRITE = 3'h2;
  localparam logic [2:0] ST_HP_WRITE = 3'h3;
  localparam logic [2:0] ST_START    = 3'h7;
  localparam logic [3:0] CMD_READ    = 4'h0;
  localparam logic [3:0] CMD_WRITE   = 4'h4;
  localparam logic [31:0] AD_RESET   = 32'h0;
  localparam logic [3:0] CBE_IDLE_N  = 4'hf;
  typedef enum logic [2:0] {
    AGPSB_ACT_NONE, AGPSB_ACT_LP_RD, AGPSB_ACT_HP_RD,
    AGPSB_ACT_LP_WR, AGPSB_ACT_HP_WR, AGPSB_ACT_START
  } agpsb_act_e;
endpackage : agpsb_pkg

// File: hdl/agpsb_if.sv
// Link carrier between the device end and the chipset end
`timescale 1ns/1ns
`default_nettype none
interface agpsb_if;
  import agpsb_pkg::*;
  logic [2:0]  arbiter_status_code;
  logic        bus_grant_n;
  logic        read_buffer_full_n;
  logic        pipelined_request_n_o;
  logic        pipelined_request_oe;
  logic [31:0] addr_data_bus_dev;
  logic        addr_data_bus_dev_oe;
  logic [31:0] addr_data_bus_tgt;
  logic        addr_data_bus_tgt_oe;
  logic [3:0]  command_byte_enable_n;
  logic        command_byte_enable_oe;
  logic        initiator_ready_n;
  logic        target_ready_n;
  logic        cycle_frame_n;
  logic        address_strobe_0_oe;
  logic        address_strobe_1_oe;
  // Resolved pipe level: pulled high when nobody drives
  logic        pipe_level_n;
  assign pipe_level_n = pipelined_request_oe ? pipelined_request_n_o : 1'b1;
  modport device (
    input  arbiter_status_code, bus_grant_n, addr_data_bus_tgt, target_ready_n,
    output read_buffer_full_n, pipelined_request_n_o, pipelined_request_oe,
    output addr_data_bus_dev, addr_data_bus_dev_oe, command_byte_enable_n,
    output command_byte_enable_oe, initiator_ready_n, cycle_frame_n,
    output address_strobe_0_oe, address_strobe_1_oe
  );
  modport chipset (
    output arbiter_status_code, bus_grant_n, addr_data_bus_tgt, addr_data_bus_tgt_oe,
    output target_ready_n,
    input  read_buffer_full_n, pipe_level_n, addr_data_bus_dev, command_byte_enable_n,
    input  initiator_ready_n, cycle_frame_n
  );
endinterface : agpsb_if
`default_nettype wire

// File: hdl/agpsb_chipset.sv
// Core-logic end: arbiter status, request capture, read return
`timescale 1ns/1ns
`default_nettype none
module agpsb_chipset
  import agpsb_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Arbiter control from user
  input  wire logic        grant_i,
  input  wire logic [2:0]  status_i,
  input  wire logic [31:0] rd_data_i,
  input  wire logic        rd_valid_i,
  // Captured requests and write data
  output logic             req_valid_o,
  output logic [31:0]      req_addr_o,
  output logic [3:0]       req_cmd_o,
  output logic             wr_valid_o,
  output logic [31:0]      wr_data_o,
  output logic             lp_blocked_o,
  // Link
  agpsb_if.chipset         link
);
  logic grant_q, trdy_q, rd_oe_q, grant_d1_q;
  logic [2:0] status_q, status_d1_q;
  logic [31:0] rd_q;

  ////////////////////////////////////////////////////////////////////////
  // Status lines always driven by this end
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      grant_q  <= 1'b0;
      status_q <= ST_START;
    end else begin
      grant_q  <= grant_i;
      status_q <= status_i;
    end
  end

  // Status as the device decoded it one cycle before its answer
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      grant_d1_q  <= 1'b0;
      status_d1_q <= ST_START;
    end else begin
      grant_d1_q  <= grant_q;
      status_d1_q <= status_q;
    end
  end

  // Low-priority return held back while device buffer is full
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      trdy_q  <= 1'b0;
      rd_oe_q <= 1'b0;
      rd_q    <= AD_RESET;
    end else begin
      trdy_q  <= rd_valid_i && grant_i && (status_i == ST_HP_READ ||
                 (status_i == ST_LP_READ && link.read_buffer_full_n));
      rd_oe_q <= rd_valid_i && grant_i && status_i inside {ST_LP_READ, ST_HP_READ};
      rd_q    <= rd_data_i;
    end
  end

  // One request captured per edge while pipe is low
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      req_valid_o  <= 1'b0;
      req_addr_o   <= AD_RESET;
      req_cmd_o    <= CMD_READ;
      wr_valid_o   <= 1'b0;
      wr_data_o    <= AD_RESET;
      lp_blocked_o <= 1'b0;
    end else begin
      req_valid_o  <= !link.pipe_level_n;
      req_addr_o   <= link.addr_data_bus_dev;
      req_cmd_o    <= ~link.command_byte_enable_n;
      // Ready also marks read blocks, so only write codes carry data
      wr_valid_o   <= !link.initiator_ready_n && link.pipe_level_n && grant_d1_q &&
                      status_d1_q inside {ST_LP_WRITE, ST_HP_WRITE};
      wr_data_o    <= link.addr_data_bus_dev;
      lp_blocked_o <= !link.read_buffer_full_n;
    end
  end

  assign link.bus_grant_n          = !grant_q;
  assign link.arbiter_status_code  = status_q;
  assign link.target_ready_n       = !trdy_q;
  assign link.addr_data_bus_tgt    = rd_q;
  assign link.addr_data_bus_tgt_oe = rd_oe_q;
endmodule // agpsb_chipset
`default_nettype wire

// File: hdl/agpsb_device.sv
// Device end: status decode, pipelined requests, buffer-full flow control
`timescale 1ns/1ns
`default_nettype none
module agpsb_device
  import agpsb_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Request source
  input  wire logic        req_valid_i,
  input  wire logic [31:0] req_addr_i,
  input  wire logic        req_write_i,
  input  wire logic        pci_req_i,
  // Write data source
  input  wire logic [31:0] wr_data_i,
  input  wire logic [3:0]  wr_be_i,
  // Read sink
  input  wire logic        lp_room_i,
  input  wire logic        rd_ready_i,
  output logic             rd_valid_o,
  output logic             rd_high_o,
  output logic [31:0]      rd_data_o,
  // Status
  output logic             req_taken_o,
  output logic             wr_taken_o,
  output logic             wr_high_o,
  output logic             frame_start_o,
  // Link
  agpsb_if.device          link
);
  typedef enum logic [1:0] {AGPSB_IDLE, AGPSB_PIPE, AGPSB_PARK} agpsb_pipe_e;

  agpsb_act_e  act;
  agpsb_pipe_e pipe_q;
  logic        pipe_n_q, pipe_oe_q, rbf_n_q, frame_n_q, irdy_n_q, ad_oe_q, cbe_oe_q;
  logic [31:0] ad_q;
  logic [3:0]  cbe_n_q;
  logic [1:0]  blk_q;

  ////////////////////////////////////////////////////////////////////////
  // Status decode under grant
  always_comb begin
    act = AGPSB_ACT_NONE;
    if (!link.bus_grant_n) begin
      case (link.arbiter_status_code)
        ST_LP_READ:  act = AGPSB_ACT_LP_RD;
        ST_HP_READ:  act = AGPSB_ACT_HP_RD;
        ST_LP_WRITE: act = AGPSB_ACT_LP_WR;
        ST_HP_WRITE: act = AGPSB_ACT_HP_WR;
        ST_START:    act = AGPSB_ACT_START;
        default:     act = AGPSB_ACT_NONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pipe sequencer: own, drive, park high one clock, release
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      pipe_q    <= AGPSB_IDLE;
      pipe_n_q  <= 1'b1;
      pipe_oe_q <= 1'b0;
    end else begin
      case (pipe_q)
        AGPSB_IDLE: begin
          if (act == AGPSB_ACT_START && req_valid_i && !pci_req_i) begin
            pipe_q    <= AGPSB_PIPE;
            pipe_n_q  <= 1'b0;
            pipe_oe_q <= 1'b1;
          end
        end
        AGPSB_PIPE: begin
          if (!req_valid_i || link.bus_grant_n) begin
            pipe_q   <= AGPSB_PARK;
            pipe_n_q <= 1'b1;
          end
        end
        AGPSB_PARK: begin
          pipe_q    <= AGPSB_IDLE;
          pipe_oe_q <= 1'b0;
        end
        default: pipe_q <= AGPSB_IDLE;
      endcase
    end
  end

  // Request handshake: one taken per edge while pipe is low
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      req_taken_o <= 1'b0;
    end else begin
      req_taken_o <= (pipe_q == AGPSB_PIPE && req_valid_i && !link.bus_grant_n) ||
                     (pipe_q == AGPSB_IDLE && act == AGPSB_ACT_START && req_valid_i &&
                      !pci_req_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address/data and command lines
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ad_q     <= AD_RESET;
      ad_oe_q  <= 1'b0;
      cbe_n_q  <= CBE_IDLE_N;
      cbe_oe_q <= 1'b0;
      irdy_n_q <= 1'b1;
    end else if (req_valid_i && !link.bus_grant_n &&
                 (pipe_q == AGPSB_PIPE || (pipe_q == AGPSB_IDLE &&
                  act == AGPSB_ACT_START && !pci_req_i))) begin
      ad_q     <= req_addr_i;
      ad_oe_q  <= 1'b1;
      cbe_n_q  <= ~(req_write_i ? CMD_WRITE : CMD_READ);
      cbe_oe_q <= 1'b1;
      irdy_n_q <= 1'b1;
    end else if (act == AGPSB_ACT_LP_WR || act == AGPSB_ACT_HP_WR) begin
      ad_q     <= wr_data_i;
      ad_oe_q  <= 1'b1;
      cbe_n_q  <= ~wr_be_i;
      cbe_oe_q <= 1'b1;
      irdy_n_q <= 1'b0;
    end else begin
      ad_oe_q  <= 1'b0;
      cbe_oe_q <= 1'b0;
      cbe_n_q  <= CBE_IDLE_N;
      irdy_n_q <= !((act == AGPSB_ACT_LP_RD || act == AGPSB_ACT_HP_RD) &&
                    (blk_q == 2'h0 || rd_ready_i));
    end
  end

  // Write-phase status; waits never inserted once ready
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_taken_o <= 1'b0;
      wr_high_o  <= 1'b0;
    end else begin
      wr_taken_o <= act == AGPSB_ACT_LP_WR || act == AGPSB_ACT_HP_WR;
      wr_high_o  <= act == AGPSB_ACT_HP_WR;
    end
  end

  // Plain bus cycle start on grant code 111
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      frame_n_q     <= 1'b1;
      frame_start_o <= 1'b0;
    end else begin
      frame_n_q     <= !(act == AGPSB_ACT_START && pci_req_i && pipe_q == AGPSB_IDLE);
      frame_start_o <= act == AGPSB_ACT_START && pci_req_i && pipe_q == AGPSB_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read return capture, counts within a block
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rd_valid_o <= 1'b0;
      rd_high_o  <= 1'b0;
      rd_data_o  <= AD_RESET;
      blk_q      <= 2'h0;
    end else begin
      rd_valid_o <= !link.target_ready_n &&
                    (act == AGPSB_ACT_LP_RD || act == AGPSB_ACT_HP_RD);
      rd_high_o  <= act == AGPSB_ACT_HP_RD;
      rd_data_o  <= link.addr_data_bus_tgt;
      if (!link.target_ready_n && (act == AGPSB_ACT_LP_RD || act == AGPSB_ACT_HP_RD))
        blk_q <= 2'(blk_q + 2'h1);
      else if (act != AGPSB_ACT_LP_RD && act != AGPSB_ACT_HP_RD)
        blk_q <= 2'h0;
    end
  end

  // Buffer-full: low when sink has no room for low-priority data
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      rbf_n_q <= 1'b1;
    end else begin
      rbf_n_q <= lp_room_i;
    end
  end

  assign link.read_buffer_full_n     = rbf_n_q;
  assign link.pipelined_request_n_o  = pipe_n_q;
  assign link.pipelined_request_oe   = pipe_oe_q;
  assign link.addr_data_bus_dev      = ad_q;
  assign link.addr_data_bus_dev_oe   = ad_oe_q;
  assign link.command_byte_enable_n  = cbe_n_q;
  assign link.command_byte_enable_oe = cbe_oe_q;
  assign link.initiator_ready_n      = irdy_n_q;
  assign link.cycle_frame_n          = frame_n_q;
  // Strobes never driven; single-edge transfers only
  assign link.address_strobe_0_oe    = 1'b0;
  assign link.address_strobe_1_oe    = 1'b0;
endmodule // agpsb_device
`default_nettype wire

// File: sim/agpsb_properties.sv
// Link checker for the sideband master interface
`timescale 1ns/1ns
`default_nettype none
module agpsb_properties
  import agpsb_pkg::*;
(
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rstn_i,
  // Link signals
  input wire logic [2:0] arbiter_status_code,
  input wire logic       bus_grant_n,
  input wire logic       pipelined_request_n_o,
  input wire logic       pipelined_request_oe,
  input wire logic       pipe_level_n,
  input wire logic [3:0] command_byte_enable_n,
  input wire logic       initiator_ready_n,
  input wire logic       cycle_frame_n,
  input wire logic       address_strobe_0_oe,
  input wire logic       address_strobe_1_oe
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  logic [2:0] code;
  logic       start;
  logic       rsvd;
  assign code  = arbiter_status_code;
  assign start = !bus_grant_n && code == ST_START;
  assign rsvd  = !bus_grant_n && code[2] && code != ST_START;
  ////////////////////////////////////////
  a_ungranted_idle: assert property (
    bus_grant_n |=> initiator_ready_n && cycle_frame_n && pipe_level_n)
    else $error("Link busy without grant");
  a_reserved_idle: assert property (
    rsvd |=> initiator_ready_n && cycle_frame_n)
    else $error("Reserved code caused action");
  a_write_phase: assert property (
    !bus_grant_n && code[2:1] == 2'h1 && !pipelined_request_oe |=> !initiator_ready_n)
    else $error("Write code gave no data phase");
  a_pipe_start: assert property (
    $fell(pipe_level_n) |-> $past(start))
    else $error("Pipe began without start code");
  a_frame_start: assert property (
    $fell(cycle_frame_n) |-> $past(start))
    else $error("Frame began without start code");
  a_pipe_command: assert property (
    !pipe_level_n |-> command_byte_enable_n == ~CMD_READ || command_byte_enable_n == ~CMD_WRITE)
    else $error("Pipe cycle without command");
  a_pipe_park: assert property (
    pipelined_request_oe && pipelined_request_n_o |=> !pipelined_request_oe)
    else $error("Pipe left driven high");
  a_pipe_release: assert property (
    $fell(pipelined_request_oe) |-> $past(pipelined_request_n_o))
    else $error("Pipe released while low");
  a_strobes_unused: assert property (
    !address_strobe_0_oe && !address_strobe_1_oe)
    else $error("Address strobe driven");
endmodule // agpsb_properties
`default_nettype wire

// File: sim/agpsb_tb.sv
// Self-checking bench joining device and chipset ends
`timescale 1ns/1ns
`default_nettype none
module agpsb_tb;
  import agpsb_pkg::*;
  typedef struct packed {
    logic       gnt;
    logic [2:0] code;
    logic       req;
    logic       pci;
    logic       room;
    logic [5:0] exp;
  } agpsb_row_s;
  logic        clk_i, rstn_i, grant_i, rd_valid_i, req_valid_i, req_write_i, pci_req_i;
  logic        lp_room_i, rd_ready_i, req_valid_o, wr_valid_o, lp_blocked_o;
  logic        rd_valid_o, rd_high_o, wr_taken_o, wr_high_o, frame_start_o, req_taken_o;
  logic [2:0]  status_i;
  logic [3:0]  wr_be_i, req_cmd_o;
  logic [31:0] rd_data_i, req_addr_i, wr_data_i, req_addr_o, wr_data_o, rd_data_o;
  logic [5:0]  seen;
  int          num_errors, compares, cycles, pipe_lows, caps, takes;
  // Seen bits: write, write high, read, read high, request, frame
  agpsb_row_s  rows [13] = '{
    '{1'b1, 3'h0, 1'b0, 1'b0, 1'b1, 6'h08},
    '{1'b1, 3'h1, 1'b0, 1'b0, 1'b1, 6'h0c},
    '{1'b1, 3'h2, 1'b0, 1'b0, 1'b1, 6'h20},
    '{1'b1, 3'h3, 1'b0, 1'b0, 1'b1, 6'h30},
    '{1'b1, 3'h4, 1'b1, 1'b0, 1'b1, 6'h00},
    '{1'b1, 3'h5, 1'b1, 1'b0, 1'b1, 6'h00},
    '{1'b1, 3'h6, 1'b1, 1'b0, 1'b1, 6'h00},
    '{1'b1, 3'h7, 1'b1, 1'b0, 1'b1, 6'h02},
    '{1'b1, 3'h7, 1'b1, 1'b1, 1'b1, 6'h01},
    '{1'b0, 3'h2, 1'b0, 1'b0, 1'b1, 6'h00},
    '{1'b0, 3'h7, 1'b1, 1'b0, 1'b1, 6'h00},
    '{1'b0, 3'h0, 1'b0, 1'b0, 1'b1, 6'h00},
    '{1'b1, 3'h0, 1'b0, 1'b0, 1'b0, 6'h00}
  };
  agpsb_if link ();
  agpsb_device u_agpsb_device (.clk_i, .rstn_i, .req_valid_i, .req_addr_i, .req_write_i,
    .pci_req_i, .wr_data_i, .wr_be_i, .lp_room_i, .rd_ready_i, .rd_valid_o, .rd_high_o,
    .rd_data_o, .req_taken_o, .wr_taken_o, .wr_high_o, .frame_start_o, .link(link));
  agpsb_chipset u_agpsb_chipset (.clk_i, .rstn_i, .grant_i, .status_i, .rd_data_i,
    .rd_valid_i, .req_valid_o, .req_addr_o, .req_cmd_o, .wr_valid_o, .wr_data_o,
    .lp_blocked_o, .link(link));
  agpsb_properties u_agpsb_properties (.clk_i, .rstn_i,
    .arbiter_status_code(link.arbiter_status_code), .bus_grant_n(link.bus_grant_n),
    .pipelined_request_n_o(link.pipelined_request_n_o), .pipe_level_n(link.pipe_level_n),
    .pipelined_request_oe(link.pipelined_request_oe), .cycle_frame_n(link.cycle_frame_n),
    .command_byte_enable_n(link.command_byte_enable_n),
    .initiator_ready_n(link.initiator_ready_n), .address_strobe_0_oe(link.address_strobe_0_oe),
    .address_strobe_1_oe(link.address_strobe_1_oe));
  ////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic ticks(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Status held two cycles, so a read lands whatever the return skew
  task automatic run_row(input agpsb_row_s r);
    req_valid_i = r.req;
    pci_req_i = r.pci;
    lp_room_i = r.room;
    ticks(3);
    seen = '0;
    grant_i = r.gnt;
    status_i = r.code;
    rd_valid_i = 1'b1;
    ticks(1);
    rd_valid_i = 1'b0;
    ticks(1);
    grant_i = 1'b0;
    req_valid_i = 1'b0;
    ticks(8);
  endtask
  // Outputs sampled mid-cycle, where registered values have settled
  // Ceiling far above the few hundred cycles the scenarios need
  always @(negedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      summarize();
    end
  end
  always @(negedge clk_i) begin
    seen |= {wr_taken_o, wr_taken_o & wr_high_o, rd_valid_o, rd_valid_o & rd_high_o,
             req_valid_o, frame_start_o};
    if (!link.pipe_level_n) pipe_lows++;
    if (req_taken_o) takes++;
    if (req_valid_o) begin
      caps++;
      check(req_addr_o, req_addr_i);
      check({28'h0, req_cmd_o}, {28'h0, (req_write_i ? CMD_WRITE : CMD_READ)});
    end
    if (wr_taken_o) check(link.addr_data_bus_dev, wr_data_i);
    if (wr_taken_o) check({28'h0, link.command_byte_enable_n}, {28'h0, ~wr_be_i});
    if (wr_taken_o) check({30'h0, link.addr_data_bus_dev_oe, link.command_byte_enable_oe}, 32'h3);
    if (wr_valid_o) check(wr_data_o, wr_data_i);
    if (rd_valid_o) check(rd_data_o, rd_data_i);
  end
  initial begin
    {num_errors, compares, cycles, pipe_lows, caps, takes} = '0;
    {rstn_i, grant_i, rd_valid_i, req_valid_i, req_write_i, pci_req_i, seen} = '0;
    {lp_room_i, rd_ready_i, status_i, wr_be_i} = {2'h3, 3'h7, 4'h9};
    {rd_data_i, req_addr_i, wr_data_i} = {32'h5a5a_0001, 32'h0000_2000, 32'h1234_abcd};
    ticks(16);
    rstn_i = 1'b1;
    ticks(2);
    for (int i = 0; i < 13; i++) begin
      run_row(rows[i]);
      check({26'h0, seen}, {26'h0, rows[i].exp});
    end
    // Buffer full follows sink room both ways
    lp_room_i = 1'b0;
    ticks(3);
    check({30'h0, link.read_buffer_full_n, lp_blocked_o}, 32'h1);
    lp_room_i = 1'b1;
    ticks(3);
    check({30'h0, link.read_buffer_full_n, lp_blocked_o}, 32'h2);
    // First read word never waits; the next waits for a sink that is not ready
    {rd_ready_i, grant_i, status_i, rd_valid_i} = {2'h1, ST_HP_READ, 1'b1};
    ticks(2);
    check({31'h0, link.initiator_ready_n}, 32'h0);
    ticks(1);
    check({31'h0, link.initiator_ready_n}, 32'h1);
    {rd_ready_i, grant_i, rd_valid_i} = 3'h4;
    ticks(8);
    // Back-to-back writes enqueued, grant lost before the source stops
    {req_write_i, req_valid_i, grant_i, status_i, pipe_lows, caps} = {3'h7, ST_START, 64'h0};
    takes = 0;
    ticks(5);
    grant_i = 1'b0;
    ticks(2);
    req_valid_i = 1'b0;
    ticks(8);
    check(caps, pipe_lows);
    check(32'(caps > 2), 32'h1);
    check(takes, caps);
    // Reset in mid-burst releases the pipe
    {req_valid_i, grant_i} = 2'h3;
    ticks(3);
    {rstn_i, grant_i, req_valid_i} = 3'h0;
    ticks(2);
    check({27'h0, link.pipelined_request_oe, link.pipe_level_n, link.read_buffer_full_n,
           link.cycle_frame_n, link.initiator_ready_n}, 32'hf);
    rstn_i = 1'b1;
    ticks(4);
    summarize();
  end
endmodule // agpsb_tb
`default_nettype wire
